// File: hw/adc_seq_pkg.sv
package adc_seq_pkg;
   // timing
   localparam int CLK_MHZ     = 100;
   localparam int ACQ_MIN_NS  = 3000;
   localparam int ACQ_MIN_CYC = (ACQ_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam logic [2:0] ACQ_CLKS     = 3'h6;
   localparam logic [2:0] ACQ_SCLK_INT = 3'h2;
   // control byte
   localparam int RES_W     = 12;
   localparam int CH_HI     = 6;
   localparam int CH_LO     = 4;
   localparam int SPAN_POS  = 3;
   localparam int POL_POS   = 2;
   localparam int PM_HI_POS = 1;
   localparam int PM_LO_POS = 0;
   localparam logic [2:0] CMD_ACQ_BIT  = 3'h6;
   localparam logic [2:0] CMD_LAST_BIT = 3'h7;
   localparam logic [3:0] D6_GATE      = 4'h6;
   localparam logic [3:0] MSB_IDX      = 4'hb;
   // register map
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] REG_RESULT = 4'h8;
   localparam logic [ADDR_W-1:0] REG_BYTE   = 4'hc;
   localparam logic [7:0] DIV_RST   = 8'h31;
   localparam int         SHORT_POS = 5;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_CMD  = 5'h02,
      ST_ACQ  = 5'h04,
      ST_CONV = 5'h08,
      ST_OUT  = 5'h10
   } seq_state_t;
endpackage

// File: hw/sar_if.sv
interface sar_if
   import adc_seq_pkg::*;
;
   logic             start;
   logic             step;
   logic             cmp;
   logic             busy;
   logic             first;
   logic [RES_W-1:0] trial;
   logic [RES_W-1:0] code;
   modport core (input start, step, cmp, output busy, first, trial, code);
   modport ctrl (output start, step, cmp, input busy, first, trial, code);
endinterface

// File: hw/pin_sync.sv
module pin_sync #(
   parameter int           W   = 3,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         clk_sys,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] raw,
   output logic      [W-1:0] stable
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change is taken only once two stages agree, so one glitch is dropped
   genvar g;
   for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_sys or negedge reset_n) begin
         if (!reset_n) begin
            stable[g] <= RST[g];
         end else if (s2_q[g] == s3_q[g]) begin
            stable[g] <= s3_q[g];
         end
      end
   end
endmodule

// File: hw/sar_core.sv
module sar_core
   import adc_seq_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic reset_n,
   sar_if.core       sar
);
   logic [RES_W-1:0] code_q;
   logic [3:0]       idx_q;
   logic             busy_q;
   logic [RES_W-1:0] bit_w;

   assign bit_w     = RES_W'(12'h001 << idx_q);
   assign sar.trial = busy_q ? (code_q | bit_w) : code_q;
   assign sar.code  = code_q;
   assign sar.busy  = busy_q;
   assign sar.first = busy_q & (idx_q == MSB_IDX);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         code_q <= '0;
         idx_q  <= MSB_IDX;
         busy_q <= 1'b0;
      end else if (sar.start) begin
         code_q <= '0;
         idx_q  <= MSB_IDX;
         busy_q <= 1'b1;
      end else if (sar.step && busy_q) begin
         code_q[idx_q] <= sar.cmp;
         busy_q        <= (idx_q != 4'h0);
         idx_q         <= idx_q - 4'h1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sar_arm_a: assert property (
      sar.start |=> busy_q && code_q == '0 && idx_q == MSB_IDX)
      else $error("approximation did not restart at the top bit");
   sar_last_a: assert property (
      busy_q && sar.step && !sar.start && idx_q == 4'h0
      |=> !busy_q && code_q[0] == $past(sar.cmp))
      else $error("twelfth decision did not end the conversion");
endmodule

// File: hw/adc_serial_control_byte_sequencer.sv
// What this block does
// - twelve-bit successive approximation after track/hold
// - tracking starts at sixth bit falling edge
// - hold after six acquisition clocks, host keeps 3us
// - internal mode: two serial, four internal clocks
// - each conversion picks one of four ranges
// - bits 6..4 select channel 0..7
// - bit 3 selects narrow or wide span
// - bit 2 selects unipolar or bipolar
// - bits 1..0 select clock and power
// - code 00: powered, internal clock
// - code 01: powered, serial clock
// - code 10: standby, clock mode kept
// - code 11: deep power-down, clock mode kept
// - first one after select low is start
// - command bits captured on rising serial edges
// - result shifted msb first on falling edges
// - reset: powered, internal clock, idle, cleared
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
module adc_serial_control_byte_sequencer
   import adc_seq_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              reset_n,
   input  wire logic              cs_n,
   input  wire logic              sclk,
   input  wire logic              din,
   output logic                   dout,
   output logic                   dout_oe,
   output logic                   sstrb,
   output logic                   sstrb_oe,
   input  wire logic              cmp_high,
   output logic [RES_W-1:0]       dac_code,
   output logic [2:0]             chan_sel,
   output logic                   span_choice,
   output logic                   polarity_choice,
   output logic                   track,
   output logic                   standby_powerdown,
   output logic                   deep_powerdown,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   function automatic logic reg_ok(input logic [ADDR_W-1:0] a);
      reg_ok = (a == REG_CTRL) || (a == REG_STATUS) ||
               (a == REG_RESULT) || (a == REG_BYTE);
   endfunction

   sar_if sar ();
   sar_core u_sar (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .sar     (sar)
   );

   logic [2:0]       pins_s;
   logic             cs_s;
   logic             sclk_s;
   logic             din_s;
   pin_sync #(.W(3), .RST(3'h4)) u_sync (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .raw     ({cs_n, sclk, din}),
      .stable  (pins_s)
   );
   assign cs_s   = pins_s[2];
   assign sclk_s = pins_s[1];
   assign din_s  = pins_s[0];

   seq_state_t       state_q;
   logic             sclk_q;
   logic             cs_q;
   logic             cs_new_q;
   logic [2:0]       bitcnt_q;
   logic [5:0]       cmd_q;
   logic [2:0]       acq_q;
   logic [15:0]      acyc_q;
   logic             short_q;
   logic             ext_q;
   logic             standby_q;
   logic             deep_q;
   logic [2:0]       ch_q;
   logic             span_q;
   logic             pol_q;
   logic             track_q;
   logic             sstrb_q;
   logic             dout_q;
   logic [RES_W-1:0] sr_q;
   logic [RES_W-1:0] result_q;
   logic [3:0]       ocnt_q;
   logic             busy_q;
   logic [7:0]       last_q;
   logic [7:0]       div_q;
   logic [7:0]       cnt_q;

   logic             rise_w;
   logic             fall_w;
   logic             cs_fall_w;
   logic             tick_w;
   logic [7:0]       byte_w;
   logic             byte_done_w;
   logic             pdn_w;
   logic             start_w;
   logic             adv_w;
   logic             acq_end_w;
   logic             int_low_w;
   logic             step_w;
   logic             sar_fin_w;
   logic [RES_W-1:0] res_fmt_w;
   logic             dec_w;
   logic             busy_w;
   logic             clr_w;

   // edges count only while selected
   assign rise_w      = ~cs_s & sclk_s & ~sclk_q;
   assign fall_w      = ~cs_s & ~sclk_s & sclk_q;
   assign cs_fall_w   = cs_q & ~cs_s;
   assign tick_w      = (cnt_q == div_q) & ~deep_q;
   assign byte_w      = {1'b1, cmd_q, din_s};
   assign byte_done_w = (state_q == ST_CMD) & rise_w &
                        (bitcnt_q == CMD_LAST_BIT);
   assign pdn_w       = byte_w[PM_HI_POS];
   // a start is accepted once d6 is out, or at once after a fresh select
   assign start_w     = rise_w & din_s & (state_q != ST_CMD) &
                        ((state_q == ST_IDLE) | (ocnt_q >= D6_GATE) |
                         cs_new_q);
   assign adv_w       = (ext_q | (acq_q < ACQ_SCLK_INT)) ? fall_w
                                                        : tick_w;
   assign acq_end_w   = (state_q == ST_ACQ) & adv_w &
                        (acq_q == ACQ_CLKS - 3'h1);
   assign int_low_w   = (state_q == ST_ACQ) & ~ext_q & fall_w &
                        (acq_q == ACQ_SCLK_INT - 3'h1);
   // conversion runs on after a new start so overlapped bytes keep data
   assign step_w      = sar.busy & (ext_q ? fall_w : tick_w);
   assign sar_fin_w   = busy_q & ~sar.busy;
   assign res_fmt_w   = {sar.code[RES_W-1] ^ pol_q,
                         sar.code[RES_W-2:0]};
   assign dec_w       = cmp_high ^ (pol_q & sar.first);
   assign busy_w      = sar.busy | (state_q == ST_CMD) |
                        (state_q == ST_ACQ);
   assign sar.start   = acq_end_w;
   assign sar.step    = step_w;
   assign sar.cmp     = cmp_high;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sclk_q <= 1'b0;
         cs_q   <= 1'b1;
         busy_q <= 1'b0;
         cnt_q  <= 8'h00;
      end else begin
         sclk_q <= sclk_s;
         cs_q   <= cs_s;
         busy_q <= sar.busy;
         cnt_q  <= (cnt_q == div_q) ? 8'h00 : cnt_q + 8'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
      end else if (start_w) begin
         state_q <= ST_CMD;
      end else begin
         case (state_q)
            ST_CMD: begin
               if (cs_s) begin
                  state_q <= ST_IDLE;
               end else if (byte_done_w) begin
                  state_q <= pdn_w ? ST_IDLE : ST_ACQ;
               end
            end
            ST_ACQ: if (acq_end_w) state_q <= ST_CONV;
            ST_CONV: if (sar_fin_w) state_q <= ST_OUT;
            ST_IDLE, ST_OUT: state_q <= state_q;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         bitcnt_q <= 3'h0;
         cmd_q    <= 6'h00;
         cs_new_q <= 1'b0;
      end else if (start_w) begin
         bitcnt_q <= 3'h1;
         cmd_q    <= 6'h00;
         cs_new_q <= 1'b0;
      end else begin
         cs_new_q <= cs_new_q | cs_fall_w;
         if ((state_q == ST_CMD) && rise_w) begin
            bitcnt_q <= bitcnt_q + 3'h1;
            cmd_q    <= {cmd_q[4:0], din_s};
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ext_q     <= 1'b0;
         standby_q <= 1'b0;
         deep_q    <= 1'b0;
         ch_q      <= 3'h0;
         span_q    <= 1'b0;
         pol_q     <= 1'b0;
         last_q    <= 8'h00;
      end else if (byte_done_w) begin
         last_q <= byte_w;
         if (pdn_w) begin
            standby_q <= ~byte_w[PM_LO_POS];
            deep_q    <= byte_w[PM_LO_POS];
         end else begin
            standby_q <= 1'b0;
            deep_q    <= 1'b0;
            ext_q     <= byte_w[PM_LO_POS];
            ch_q      <= byte_w[CH_HI:CH_LO];
            span_q    <= byte_w[SPAN_POS];
            pol_q     <= byte_w[POL_POS];
         end
      end
   end

   // a short external-clock acquisition is flagged, not stretched: the host owns it
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         track_q <= 1'b0;
         acq_q   <= 3'h0;
         acyc_q  <= 16'h0000;
         short_q <= 1'b0;
      end else begin
         short_q <= (acq_end_w & ext_q & (acyc_q < 16'(ACQ_MIN_CYC))) |
                    (short_q & ~clr_w);
         if (start_w || acq_end_w || (byte_done_w && pdn_w)) begin
            track_q <= 1'b0;
         end else if ((state_q == ST_CMD) && fall_w &&
                      (bitcnt_q == CMD_ACQ_BIT)) begin
            track_q <= 1'b1;
            acq_q   <= 3'h0;
            acyc_q  <= 16'h0000;
         end else if (track_q) begin
            if (acyc_q != 16'hffff) acyc_q <= acyc_q + 16'h0001;
            if (adv_w) acq_q <= acq_q + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sstrb_q <= 1'b1;
      end else if (byte_done_w && !pdn_w) begin
         sstrb_q <= ~byte_w[PM_LO_POS];
      end else if (int_low_w) begin
         sstrb_q <= 1'b0;
      end else if (acq_end_w) begin
         sstrb_q <= ext_q;
      end else if (ext_q && (fall_w || cs_fall_w)) begin
         sstrb_q <= 1'b0;
      end else if (sar_fin_w && !ext_q) begin
         sstrb_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         result_q <= '0;
         sr_q     <= '0;
         dout_q   <= 1'b0;
         ocnt_q   <= 4'h0;
      end else if (start_w || acq_end_w) begin
         ocnt_q <= 4'h0;
      end else if (step_w && ext_q) begin
         dout_q <= dec_w;
         ocnt_q <= ocnt_q + 4'h1;
      end else if (sar_fin_w) begin
         result_q <= res_fmt_w;
         sr_q     <= ext_q ? '0 : {res_fmt_w[RES_W-2:0], 1'b0};
         if (!ext_q) begin
            dout_q <= res_fmt_w[RES_W-1];
            ocnt_q <= 4'h1;
         end
      end else if (fall_w) begin
         dout_q <= sr_q[RES_W-1];
         sr_q   <= {sr_q[RES_W-2:0], 1'b0};
         if (ocnt_q != 4'hf) ocnt_q <= ocnt_q + 4'h1;
      end else if (cs_fall_w && ext_q) begin
         dout_q <= 1'b0;
      end
   end

   assign dout              = dout_q;
   assign dout_oe           = ~cs_s;
   assign sstrb             = sstrb_q;
   assign sstrb_oe          = ext_q ? ~cs_s : 1'b1;
   assign dac_code          = sar.trial;
   assign chan_sel          = ch_q;
   assign span_choice       = span_q;
   assign polarity_choice   = pol_q;
   assign track             = track_q;
   assign standby_powerdown = standby_q;
   assign deep_powerdown    = deep_q;

   // register slave
   logic                aw_q;
   logic                w_q;
   logic [ADDR_W-1:0]   awaddr_q;
   logic [31:0]         wdata_q;
   logic [3:0]          wstrb_q;
   logic                bvalid_q;
   logic [1:0]          bresp_q;
   logic                rvalid_q;
   logic [1:0]          rresp_q;
   logic [31:0]         rdata_q;
   logic                wr_go_w;
   logic [31:0]         rd_mux_w;

   assign wr_go_w  = aw_q & w_q & ~bvalid_q;
   assign clr_w    = wr_go_w & (awaddr_q == REG_STATUS) & wstrb_q[0] &
                     wdata_q[SHORT_POS];
   assign rd_mux_w =
      (s_axi_araddr == REG_CTRL)   ? {24'h000000, div_q} :
      (s_axi_araddr == REG_STATUS) ? {26'h0000000, short_q, deep_q,
                                      standby_q, ext_q, track_q, busy_w} :
      (s_axi_araddr == REG_RESULT) ? {20'h00000, result_q} :
      (s_axi_araddr == REG_BYTE)   ? {24'h000000, last_q} : 32'h00000000;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         awaddr_q <= '0;
         wdata_q  <= 32'h00000000;
         wstrb_q  <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_q) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (wr_go_w) begin
            aw_q <= 1'b0;
         end
         if (s_axi_wvalid && !w_q) begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (wr_go_w) begin
            w_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
         div_q    <= DIV_RST;
      end else if (wr_go_w) begin
         bvalid_q <= 1'b1;
         bresp_q  <= reg_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
         if ((awaddr_q == REG_CTRL) && wstrb_q[0]) div_q <= wdata_q[7:0];
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rvalid_q <= 1'b0;
         rresp_q  <= RESP_OKAY;
         rdata_q  <= 32'h00000000;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_mux_w;
         rresp_q  <= reg_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_awready = ~aw_q;
   assign s_axi_wready  = ~w_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence byte_end_s;
      byte_done_w && !start_w;
   endsequence
   sequence idle_one_s;
      state_q == ST_IDLE && rise_w && din_s;
   endsequence

   acq_begin_a: assert property (
      state_q == ST_CMD && fall_w && bitcnt_q == CMD_ACQ_BIT && !start_w
      |=> track_q && acq_q == 3'h0)
      else $error("tracking did not begin at sixth bit");
   hold_conv_a: assert property (
      acq_end_w |=> !track_q && sar.busy && sar.first)
      else $error("hold and conversion did not follow acquisition");
   int_wait_a: assert property (
      state_q == ST_ACQ && !ext_q && acq_q >= ACQ_SCLK_INT && !tick_w
      |=> $stable(acq_q))
      else $error("internal acquisition advanced without a tick");
   chan_latch_a: assert property (
      byte_end_s ##0 !pdn_w |=> ch_q == $past(byte_w[CH_HI:CH_LO]))
      else $error("channel code not latched");
   span_latch_a: assert property (
      byte_end_s ##0 !pdn_w |=> span_choice == $past(byte_w[SPAN_POS]))
      else $error("span choice not latched");
   pol_latch_a: assert property (
      byte_end_s ##0 !pdn_w |=> polarity_choice == $past(byte_w[POL_POS]))
      else $error("polarity choice not latched");
   clk_mode_a: assert property (
      byte_end_s ##0 !pdn_w
      |=> ext_q == $past(din_s) && !standby_q && !deep_q)
      else $error("clock mode not taken from mode field");
   pd_keep_a: assert property (
      byte_end_s ##0 pdn_w
      |=> $stable(ext_q) && deep_q == $past(din_s) && state_q == ST_IDLE)
      else $error("power-down changed the clock mode");
   start_take_a: assert property (
      idle_one_s |=> state_q == ST_CMD && bitcnt_q == 3'h1)
      else $error("start marker not taken");
   ext_strobe_a: assert property (
      acq_end_w && ext_q |=> sstrb_q)
      else $error("strobe missing at end of acquisition");
   msb_out_a: assert property (
      sar_fin_w && !ext_q && !start_w |=> dout_q == result_q[RES_W-1])
      else $error("msb not presented first");
   cs_quiet_a: assert property (
      cs_s && state_q == ST_IDLE |=> state_q == ST_IDLE)
      else $error("activity accepted while deselected");
endmodule

// File: tb/spi_host_model.sv
module spi_host_model (
   input  wire logic        clk_sys,
   input  wire logic        dout,
   input  wire logic        sstrb,
   output logic             cs_n,
   output logic             sclk,
   output logic             din,
   output logic             done,
   output logic [11:0]      res
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
      done = 1'b0;
      res = 12'h000;
   end
   // deselected data line toggles so a stale level proves nothing
   always @(posedge clk_sys) if (cs_n) din <= ~din;
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // clock idles low, data set while low, sampled on the rise
   task automatic bit_io(input logic d, output logic s);
      din <= d;
      wt(4);
      sclk <= 1'b1;
      wt(4);
      s = dout;
      sclk <= 1'b0;
   endtask
   task automatic frame(input logic [7:0] b, input int lead, nrd,
                        input bit intm);
      logic s;
      int   n;
      cs_n <= 1'b0;
      wt(4);
      for (int i = 0; i < lead + 8; i++)
         bit_io(i < lead ? 1'b0 : b[lead + 7 - i], s);
      if (nrd != 0) begin
         if (intm) begin
            n = 0;
            wt(8);
            while (sstrb !== 1'b1 && n < 2000) begin
               wt(1);
               n++;
            end
            for (int i = 11; i >= 0; i--) begin
               res[i] = dout;
               bit_io(1'b0, s);
               wt(8);
            end
         end else begin
            // low phases stretched so the hold comes after 3us
            for (int i = 0; i < 5; i++) begin
               bit_io(1'b0, s);
               wt(100);
            end
            for (int i = 11; i >= 0; i--) begin
               bit_io(1'b0, s);
               res[i] = s;
            end
         end
         done <= 1'b1;
         wt(1);
         done <= 1'b0;
      end
      wt(4);
      cs_n <= 1'b1;
      wt(8);
   endtask
endmodule

// File: tb/adc_serial_control_byte_sequencer_tb.sv
module adc_serial_control_byte_sequencer_tb
   import adc_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_sys = 1'b0;
   logic        reset_n = 1'b0;
   logic        cmp_high, cs_n, sclk, din, dout, dout_oe, sstrb, sstrb_oe;
   logic        span_choice, polarity_choice, track, done;
   logic        standby_powerdown, deep_powerdown;
   logic [11:0] dac_code, ain, res, ex;
   logic [2:0]  chan_sel;
   logic [7:0]  cb;
   logic [31:0] rnd, s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [11:0] ser_q[$];
   logic [33:0] axi_q[$];
   int          fail_count, samples_checked;
   always #5 clk_sys = ~clk_sys;
   // ideal comparator, so the search must land on ain exactly
   assign cmp_high = ain >= dac_code;
   adc_serial_control_byte_sequencer dut_u (.clk_sys, .reset_n, .cs_n,
      .sclk, .din, .dout, .dout_oe, .sstrb, .sstrb_oe, .cmp_high, .dac_code,
      .chan_sel, .span_choice, .polarity_choice, .track, .standby_powerdown,
      .deep_powerdown, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   spi_host_model host_u (.clk_sys, .dout, .sstrb, .cs_n, .sclk, .din,
      .done, .res);
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      if (done) check(34'(res), 34'(ser_q.pop_front()));
      if (s_axi_rvalid && s_axi_rready)
         check({s_axi_rresp, s_axi_rdata}, axi_q.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         check({s_axi_bresp, 32'h0}, axi_q.pop_front());
   end
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      bit aw = 1'b1, w = 1'b1, b = 1'b1;
      // one edge between calls, so no strobe is set twice in a step
      @(posedge clk_sys);
      axi_q.push_back({r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw || w || b) begin
         @(posedge clk_sys);
         aw = aw && !s_axi_awready;
         w = w && !s_axi_wready;
         b = b && !s_axi_bvalid;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
         s_axi_bready <= b;
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      bit ar = 1'b1, rr = 1'b1;
      @(posedge clk_sys);
      axi_q.push_back({r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (ar || rr) begin
         @(posedge clk_sys);
         ar = ar && !s_axi_arready;
         rr = rr && !s_axi_rvalid;
         s_axi_arvalid <= ar;
         s_axi_rready <= rr;
      end
   endtask
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 10'h000;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      ain = 12'h000;
      rnd = 32'h13b83e82;
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      check(34'({track, standby_powerdown, deep_powerdown, chan_sel,
                 dout_oe}), 34'h0);
      rd(REG_CTRL, 32'(DIV_RST), RESP_OKAY);
      rd(REG_RESULT, 32'h0, RESP_OKAY);
      rd(4'h2, 32'h0, RESP_SLVERR);
      wr(4'h2, 32'h1, RESP_SLVERR);
      // short divider keeps internal-clock conversions brief
      wr(REG_CTRL, 32'h1, RESP_OKAY);
      for (int k = 0; k < 10; k++) begin
         cb = {1'b1, 3'(k), k[0], k[1], 1'b0, k < 8};
         rnd = lfsr(rnd);
         ain <= rnd[11:0];
         ex = k[1] ? {~rnd[11], rnd[10:0]} : rnd[11:0];
         ser_q.push_back(ex);
         host_u.frame(cb, k % 3, 1, k >= 8);
         check(34'({chan_sel, span_choice, polarity_choice, dout_oe,
                    sstrb_oe}),
               34'({cb[6:2], 1'b0, ~cb[0]}));
         rd(REG_BYTE, 32'(cb), RESP_OKAY);
         rd(REG_RESULT, 32'(ex), RESP_OKAY);
      end
      rd(REG_STATUS, 32'h0, RESP_OKAY);
      host_u.frame(8'h82, 0, 0, 1'b0);
      check(34'({standby_powerdown, deep_powerdown}), 34'h2);
      host_u.frame(8'h83, 0, 0, 1'b0);
      check(34'(deep_powerdown), 34'h1);
      rd(REG_STATUS, 32'h10, RESP_OKAY);
      give_verdict();
   end
   initial begin
      repeat (30000) @(posedge clk_sys);
      fail_count++;
      give_verdict();
   end
endmodule
